/* File: src/snv_port.sv */
/*
 serial command port of a shadowed 16 x 16 nonvolatile ram.
 assumes serial pins are asynchronous to i_sys_clk and slow (<= 1 MHz),
 and that the nonvolatile cells are modelled as a register copy here.
*/
// Overview of operation
// - instruction is start bit one, four address bits, three opcode bits
// - opcode 011 writes a word at the instruction address
// - a write takes exactly sixteen data bits after the instruction
// - opcodes 11X read; the final instruction bit is ignored
// - read data: first bit after eighth falling edge, rest on rises
// - opcode 100 sets write enable, 000 clears it
// - serial input sampled on each rising serial clock edge
// - serial output released except while shifting read data
// - select drop mid instruction discards it and clears shifter
// - write enable starts cleared after power-up
// - write enable stays set until disable, store end or power loss
// - reads work regardless of write enable
// - recall by command or pin sets the prior recall latch
// - writes and stores refused until a recall has happened
// - power-up recall and all functions held off for 240 ns (six cycles)
// - store needs prior recall, write enable and a request
// - store blocks everything else and clears write enable at end
// - low supply blocks stores and clears write enable
// - recalled data present in ram within 1.5 us
// - store finishes within 10 ms, holding off other work
// - a store request that has prior recall, write enable and no low supply beats a pending recall
`timescale 1ns/10ps
`include "snv_map.svh"
module snv_port
   import snv_pkg::*;
#(
   parameter int STORE_CYC = `SNV_STORE_CYC_DEF
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_clk_en,
   input wire logic i_serial_clock,
   input wire logic i_chip_select,
   input wire logic i_serial_in,
   input wire logic i_store_req_n,
   input wire logic i_recall_req_n,
   input wire logic i_low_supply,
   output logic o_serial_out,
   output logic o_serial_out_oe,
   output logic o_write_enable_latch,
   output logic o_prior_recall_latch,
   output logic o_busy
);
   // two-stage synchronisers for all pins
   logic [4:0] sync1;
   logic [4:0] sync2;
   logic sck_d;
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sync1 <= 5'h00;
         sync2 <= 5'h00;
         sck_d <= 1'b0;
      end
      else if (i_clk_en)
      begin
         sync1 <= {~i_store_req_n, ~i_recall_req_n, i_low_supply,
                   i_chip_select, i_serial_clock};
         sync2 <= sync1;
         sck_d <= sync2[0];
      end
   end
   logic di_s1;
   logic di_s2;
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         di_s1 <= 1'b0;
         di_s2 <= 1'b0;
      end
      else if (i_clk_en)
      begin
         di_s1 <= i_serial_in;
         di_s2 <= di_s1;
      end
   end

   wire sck = sync2[0];
   wire cs = sync2[1];
   wire low_vcc = sync2[2];
   wire recall_pin = sync2[3];
   wire store_pin = sync2[4];
   wire sck_rise = sck & ~sck_d;
   wire sck_fall = ~sck & sck_d;

   snv_op_state_type op_state;
   snv_op_state_type next_op_state;
   snv_shift_state_type sh_state;
   snv_shift_state_type next_sh_state;
   logic [`SNV_INSTR_BITS-1:0] instr;
   logic [3:0] icount;
   logic [4:0] dcount;
   logic [`SNV_DW-1:0] shreg;
   logic [`SNV_AW-1:0] addr;
   logic wel;
   logic prl;
   logic store_pend;
   logic recall_pend;
   logic [23:0] timer;
   logic [`SNV_AW-1:0] copy_idx;
   logic [`SNV_DW-1:0] nv [0:`SNV_WORDS-1];
   logic dout;
   logic dout_oe;

   // decode of the completed instruction
   wire [2:0] opcode = {instr[1:0], di_s2};
   wire start_ok = instr[6];
   wire instr_done = (sh_state == SNV_SH_INSTR) & sck_rise & cs
                     & (icount == 4'h7);
   wire is_read = opcode[2:1] == `SNV_OP_READ_MSB;
   wire cmd_write = instr_done & start_ok & (opcode == `SNV_OP_WRITE);
   wire cmd_enable = instr_done & start_ok & (opcode == `SNV_OP_ENABLE);
   wire cmd_disable = instr_done & start_ok & (opcode == `SNV_OP_DISABLE);
   wire cmd_store = instr_done & start_ok & (opcode == `SNV_OP_STORE);
   wire cmd_recall = instr_done & start_ok & (opcode == `SNV_OP_RECALL);
   wire cmd_read = instr_done & start_ok & is_read;
   // opcode 010 matches none of the above and leaves all state alone
   wire idle = op_state == SNV_IDLE;
   wire data_done = (sh_state == SNV_SH_WDATA) & sck_rise & cs
                    & (dcount == 5'h0F);
   wire ram_write_ok = data_done & wel & prl & idle;
   wire store_go = idle & prl & wel & ~low_vcc
                   & (store_pend | store_pin);
   wire recall_go = idle & ~store_go & (recall_pend | recall_pin);

   // ram port sharing: recall copy, store copy-out address, serial write, else serial read address
   wire in_recall = op_state == SNV_RECALL;
   wire mem_we = in_recall | ram_write_ok;
   wire [`SNV_AW-1:0] mem_addr = (in_recall | op_state == SNV_STORE)
                                 ? copy_idx : addr;
   wire [`SNV_DW-1:0] mem_wdata = in_recall ? nv[copy_idx]
                                  : {shreg[`SNV_DW-2:0], di_s2};
   logic [`SNV_DW-1:0] mem_rdata;
   snv_mem u_mem
   (
      .i_sys_clk(i_sys_clk),
      .i_ce(i_clk_en),
      .i_we(mem_we),
      .i_addr(mem_addr),
      .i_wdata(mem_wdata),
      .o_rdata(mem_rdata)
   );

   // serial shifter state
   always_comb
   begin
      next_sh_state = sh_state;
      case (sh_state)
         SNV_SH_INSTR:
            if (instr_done)
            begin
               if (cmd_write)
                  next_sh_state = SNV_SH_WDATA;
               else if (cmd_read)
                  next_sh_state = SNV_SH_RDATA;
               else
                  next_sh_state = SNV_SH_DONE;
            end
         SNV_SH_WDATA:
            if (data_done)
               next_sh_state = SNV_SH_DONE;
         SNV_SH_RDATA:
            if (sck_rise & (dcount == 5'h0F))
               next_sh_state = SNV_SH_DONE;
         SNV_SH_DONE:
            next_sh_state = SNV_SH_DONE;
         default:
            next_sh_state = SNV_SH_INSTR;
      endcase
      // deselect resets the shifter; busy ops ignore the port entirely
      if (~cs | ~idle)
         next_sh_state = SNV_SH_INSTR;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         sh_state <= SNV_SH_INSTR;
         instr <= 8'h00;
         icount <= 4'h0;
         dcount <= 5'h00;
         shreg <= 16'h0000;
         addr <= 4'h0;
      end
      else if (i_clk_en)
      begin
         sh_state <= next_sh_state;
         if (~cs | ~idle)
         begin
            instr <= 8'h00;
            icount <= 4'h0;
            dcount <= 5'h00;
         end
         else if (sh_state == SNV_SH_INSTR && sck_rise)
         begin
            // leading zeros before the start bit are skipped
            if (icount != 4'h0 || di_s2)
               icount <= icount + 4'h1;
            instr <= {instr[6:0], di_s2};
            if (icount == 4'h4)
               addr <= {instr[2:0], di_s2};
            dcount <= 5'h00;
         end
         else if (sh_state != SNV_SH_INSTR && sck_rise)
         begin
            dcount <= dcount + 5'h01;
            shreg <= {shreg[`SNV_DW-2:0], di_s2};
         end
      end
   end

   // read data output: load at 8th fall, shift on later rises
   logic rd_loaded;
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         dout <= 1'b0;
         dout_oe <= 1'b0;
         rd_loaded <= 1'b0;
      end
      else if (i_clk_en)
      begin
         if (sh_state != SNV_SH_RDATA || ~cs)
         begin
            dout_oe <= 1'b0;
            rd_loaded <= 1'b0;
         end
         else if (sck_fall && !rd_loaded)
         begin
            dout <= mem_rdata[`SNV_DW-1];
            dout_oe <= 1'b1;
            rd_loaded <= 1'b1;
         end
         else if (sck_rise && rd_loaded)
            dout <= mem_rdata[4'hE - dcount[3:0]];
      end
   end

   // store/recall sequencer
   always_comb
   begin
      next_op_state = op_state;
      case (op_state)
         SNV_POWERUP:
            if (timer == 24'(`SNV_PWRUP_CYC))
               next_op_state = SNV_RECALL;
         SNV_IDLE:
            if (store_go)
               next_op_state = SNV_STORE;
            else if (recall_go)
               next_op_state = SNV_RECALL;
         SNV_RECALL:
            if (copy_idx == 4'hF)
               next_op_state = SNV_IDLE;
         SNV_STORE:
            if (timer == 24'(STORE_CYC - 1))
               next_op_state = SNV_IDLE;
         default:
            next_op_state = SNV_IDLE;
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         op_state <= SNV_POWERUP;
         timer <= 24'h000000;
         copy_idx <= 4'h0;
         wel <= 1'b0;
         prl <= 1'b0;
         store_pend <= 1'b0;
         recall_pend <= 1'b0;
      end
      else if (i_clk_en)
      begin
         op_state <= next_op_state;
         timer <= (next_op_state != op_state) ? 24'h000000
                  : timer + 24'h000001;
         copy_idx <= (next_op_state != op_state) ? 4'h0
                     : copy_idx + 4'h1;
         if (cmd_store)
            store_pend <= 1'b1;
         else if (store_go | ~idle | ~(prl & wel) | low_vcc)
            store_pend <= 1'b0; // unqualified store is simply dropped
         if (cmd_recall)
            recall_pend <= 1'b1;
         else if (recall_go)
            recall_pend <= 1'b0;
         if (op_state == SNV_RECALL && next_op_state == SNV_IDLE)
            prl <= 1'b1;
         if (low_vcc)
            wel <= 1'b0;
         else if (op_state == SNV_STORE && next_op_state == SNV_IDLE)
            wel <= 1'b0;
         else if (cmd_disable)
            wel <= 1'b0;
         else if (cmd_enable & idle)
            wel <= 1'b1;
      end
   end

   // nonvolatile copy: one word per cycle during the first store cycles
   always_ff @(posedge i_sys_clk)
   begin
      // read port lags its address by one cycle: word k lands at timer k+1
      if (i_clk_en && op_state == SNV_STORE && timer >= 24'h000001
          && timer <= 24'(`SNV_WORDS))
         nv[4'(timer - 24'h000001)] <= mem_rdata;
   end

   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
      begin
         o_serial_out <= 1'b0;
         o_serial_out_oe <= 1'b0;
         o_write_enable_latch <= 1'b0;
         o_prior_recall_latch <= 1'b0;
         o_busy <= 1'b1;
      end
      else if (i_clk_en)
      begin
         o_serial_out <= dout;
         o_serial_out_oe <= dout_oe;
         o_write_enable_latch <= wel;
         o_prior_recall_latch <= prl;
         o_busy <= ~idle;
      end
   end
endmodule : snv_port

/* File: src/snv_map.svh */
/*
 constants for the serial nvram command port: instruction layout,
 opcodes, array shape and timing counts. assumes a 25 MHz system clock.
*/
`ifndef SNV_MAP_SVH
`define SNV_MAP_SVH
`define SNV_WORDS 16
`define SNV_AW 4
`define SNV_DW 16
`define SNV_INSTR_BITS 4'h8
`define SNV_DATA_BITS 5'h10
`define SNV_OP_DISABLE 3'h0
`define SNV_OP_STORE 3'h1
`define SNV_OP_NOP 3'h2
`define SNV_OP_WRITE 3'h3
`define SNV_OP_ENABLE 3'h4
`define SNV_OP_RECALL 3'h5
`define SNV_OP_READ_MSB 2'h3
`define SNV_CLK_NS 40
`define SNV_PWRUP_NS 200
`define SNV_PWRUP_CYC ((`SNV_PWRUP_NS + `SNV_CLK_NS - 1) / `SNV_CLK_NS)
`define SNV_RECALL_NS 1500
`define SNV_RECALL_CYC (`SNV_RECALL_NS / `SNV_CLK_NS)
`define SNV_STORE_MS 10
`define SNV_STORE_CYC_DEF ((`SNV_STORE_MS * 1000000) / `SNV_CLK_NS)
`endif

/* File: src/snv_pkg.sv */
/*
 types for the serial nvram command port.
 assumes nothing beyond the constants header.
*/
package snv_pkg;
   typedef enum logic [2:0] {
      SNV_POWERUP,
      SNV_IDLE,
      SNV_RECALL,
      SNV_STORE
   } snv_op_state_type;
   typedef enum logic [1:0] {
      SNV_SH_INSTR,
      SNV_SH_WDATA,
      SNV_SH_RDATA,
      SNV_SH_DONE
   } snv_shift_state_type;
endpackage : snv_pkg

/* File: src/snv_mem.sv */
/*
 16 x 16 storage array with one write port and a registered read port on a shared address.
 assumes one write source at a time, chosen by the caller.
*/
`timescale 1ns/10ps
`include "snv_map.svh"
module snv_mem
(
   input wire logic i_sys_clk,
   input wire logic i_ce,
   input wire logic i_we,
   input wire logic [`SNV_AW-1:0] i_addr,
   input wire logic [`SNV_DW-1:0] i_wdata,
   output logic [`SNV_DW-1:0] o_rdata
);
   logic [`SNV_DW-1:0] mem [0:`SNV_WORDS-1];

   // no reset: contents come from the power-up recall
   always_ff @(posedge i_sys_clk)
   begin
      if (i_ce)
      begin
         if (i_we)
            mem[i_addr] <= i_wdata;
         o_rdata <= mem[i_addr];
      end
   end
endmodule : snv_mem

/* File: sim/snv_port_props.sv */
/*
 checker for snv_port: pin timing and status latches.
 assumes serial clock halves of eight or more system cycles.
*/
`timescale 1ns/10ps
module snv_port_props
#(
   parameter int STORE_CYC = 40
)
(
   input wire logic i_sys_clk,
   input wire logic i_rst,
   input wire logic i_serial_clock,
   input wire logic i_chip_select,
   input wire logic i_low_supply,
   input wire logic o_serial_out,
   input wire logic o_serial_out_oe,
   input wire logic o_write_enable_latch,
   input wire logic o_prior_recall_latch,
   input wire logic o_busy
);
   logic [31:0] busy_cnt;
   // a counter, since a store is far too long for a repetition
   always_ff @(posedge i_sys_clk or posedge i_rst)
   begin
      if (i_rst)
         busy_cnt <= 32'h0;
      else
         busy_cnt <= o_busy ? busy_cnt + 32'h1 : 32'h0;
   end
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);
   sequence pwr_hold;
      o_busy [*5];
   endsequence
   sequence pwr_done;
      !o_busy && !o_write_enable_latch;
   endsequence
   pwr_up_a: assert property (
      $fell(i_rst) |-> pwr_hold ##[1:40] pwr_done)
      else $error("power-up hold or recall wrong");
   wel_init_a: assert property (
      o_busy && !o_prior_recall_latch |-> !o_write_enable_latch)
      else $error("write enable set before first recall");
   busy_end_a: assert property (
      $fell(o_busy) |-> ##[0:2] o_prior_recall_latch)
      else $error("prior recall missing after busy");
   pr_keep_a: assert property (
      o_prior_recall_latch |=> o_prior_recall_latch)
      else $error("prior recall latch dropped");
   busy_len_a: assert property (
      busy_cnt <= 32'(STORE_CYC + 4))
      else $error("busy too long");
   wel_busy_a: assert property (
      o_busy |=> !$rose(o_write_enable_latch))
      else $error("write enable rose while busy");
   low_sup_a: assert property (
      i_low_supply [*5] |-> !o_write_enable_latch)
      else $error("write enable kept on low supply");
   oe_idle_a: assert property (
      !i_chip_select [*5] |-> !o_serial_out_oe)
      else $error("output driven while deselected");
   oe_start_a: assert property (
      $rose(o_serial_out_oe) |-> i_chip_select && !i_serial_clock)
      else $error("output enabled off the falling clock");
   bit_edge_a: assert property (
      o_serial_out_oe && $past(o_serial_out_oe, 2) && $changed(o_serial_out)
      |-> i_serial_clock)
      else $error("read bit moved off the rising clock");
endmodule : snv_port_props
bind snv_port snv_port_props #(.STORE_CYC(STORE_CYC)) props_u (
   .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_serial_clock(i_serial_clock),
   .i_chip_select(i_chip_select), .i_low_supply(i_low_supply),
   .o_serial_out(o_serial_out), .o_serial_out_oe(o_serial_out_oe),
   .o_write_enable_latch(o_write_enable_latch),
   .o_prior_recall_latch(o_prior_recall_latch), .o_busy(o_busy));

/* File: sim/snv_host.sv */
/*
 host model driving serial clock, select and serial input.
 assumes calls start on a rising system clock edge.
*/
`timescale 1ns/10ps
module snv_host
(
   input wire logic i_sys_clk,
   input wire logic i_serial_out,
   input wire logic i_serial_out_oe,
   output logic o_serial_clock,
   output logic o_chip_select,
   output logic o_serial_in
);
   // 26 system cycles a period keeps the serial clock under 1 MHz
   localparam int HALF = 13;
   initial
   begin
      o_serial_clock = 1'b0;
      o_chip_select = 1'b0;
      o_serial_in = 1'b0;
   end
   task automatic xfer(input logic [23:0] bits, input int n,
      output logic [15:0] rd, output logic oe_ok);
      rd = 16'h0;
      oe_ok = 1'b1;
      o_chip_select <= 1'b1;
      for (int i = 0; i < n; i++)
      begin
         o_serial_in <= bits[23 - i];
         repeat (HALF) @(posedge i_sys_clk);
         if (i >= 8)
         begin
            rd = {rd[14:0], i_serial_out};
            oe_ok &= i_serial_out_oe;
         end
         o_serial_clock <= 1'b1;
         repeat (HALF) @(posedge i_sys_clk);
         o_serial_clock <= 1'b0;
      end
      repeat (HALF) @(posedge i_sys_clk);
      o_chip_select <= 1'b0;
      o_serial_in <= ~o_serial_in;
      repeat (2 * HALF) @(posedge i_sys_clk);
   endtask : xfer
endmodule : snv_host

/* File: sim/serial_nvram_command_port_tb.sv */
/*
 self-checking bench for snv_port with a host model on the serial pins.
 assumes the store count is shortened to forty cycles.
*/
`timescale 1ns/10ps
`include "snv_map.svh"
module serial_nvram_command_port_tb;
   localparam int STORE_CYC = 40;
   logic i_sys_clk = 1'b0;
   logic i_rst = 1'b1;
   logic store_n = 1'b1;
   logic recall_n = 1'b1;
   logic low_sup = 1'b0;
   logic sck, cs, sin, sout, oe, wel, pr, busy, hit, oe_ok;
   logic [15:0] rd;
   int err_total = 0;
   int comparisons = 0;
   int busy_cyc = 0;
   always #20 i_sys_clk = ~i_sys_clk;
   // a short store or recall ends inside the transfer tail, so count it
   always @(posedge i_sys_clk)
      if (busy === 1'b1)
         busy_cyc <= busy_cyc + 1;
   snv_port #(.STORE_CYC(STORE_CYC)) dut_u (.i_sys_clk(i_sys_clk),
      .i_rst(i_rst), .i_clk_en(1'b1), .i_serial_clock(sck),
      .i_chip_select(cs), .i_serial_in(sin), .i_store_req_n(store_n),
      .i_recall_req_n(recall_n), .i_low_supply(low_sup),
      .o_serial_out(sout), .o_serial_out_oe(oe),
      .o_write_enable_latch(wel), .o_prior_recall_latch(pr),
      .o_busy(busy));
   snv_host host_u (.i_sys_clk(i_sys_clk), .i_serial_out(sout),
      .i_serial_out_oe(oe), .o_serial_clock(sck), .o_chip_select(cs),
      .o_serial_in(sin));
   task automatic chk1(input logic got, input logic exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t flag %b want %b", $time, got, exp);
      end
   endtask : chk1
   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      comparisons++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] %0t word %h want %h", $time, got, exp);
      end
   endtask : chk16
   task automatic close_out();
      $display("checks %0d errors %0d", comparisons, err_total);
      if (err_total == 0 && comparisons > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : close_out
   task automatic idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 300)
      begin
         @(posedge i_sys_clk);
         n++;
      end
      if (n >= 300)
         chk1(busy, 1'b0);
   endtask : idle
   task automatic send(input logic [2:0] op, input logic [3:0] a,
      input logic [15:0] wd);
      int n;
      int b0;
      n = (op == `SNV_OP_WRITE || op[2:1] == `SNV_OP_READ_MSB) ? 24 : 8;
      b0 = busy_cyc;
      host_u.xfer({1'b1, a, op, wd}, n, rd, oe_ok);
      hit = (busy_cyc != b0);
      idle();
   endtask : send
   task automatic rdchk(input logic [3:0] a, input logic [15:0] exp);
      send({`SNV_OP_READ_MSB, a[0]}, a, 16'h5AA5);
      chk16(rd, exp);
      chk1(oe_ok, 1'b1);
      chk1(oe, 1'b0);
   endtask : rdchk
   // pins released early, as they are level requests and would restart
   task automatic pins(input logic s, input logic r);
      store_n <= s;
      recall_n <= r;
      repeat (10) @(posedge i_sys_clk);
      hit = busy;
      store_n <= 1'b1;
      recall_n <= 1'b1;
      @(posedge i_sys_clk);
      idle();
   endtask : pins
   initial
   begin
      repeat (6) @(posedge i_sys_clk);
      i_rst <= 1'b0;
      repeat (2) @(posedge i_sys_clk);
      chk1(busy, 1'b1);
      idle();
      chk1(pr, 1'b1);
      chk1(wel, 1'b0);
      send(`SNV_OP_ENABLE, 4'h0, 16'h0);
      chk1(wel, 1'b1);
      for (int i = 0; i < 16; i++)
         send(`SNV_OP_WRITE, i[3:0], {4{i[3:0]}} ^ 16'hC3A5);
      for (int i = 0; i < 16; i++)
         rdchk(i[3:0], {4{i[3:0]}} ^ 16'hC3A5);
      host_u.xfer({1'b1, 4'h5, `SNV_OP_WRITE, 16'h0}, 5, rd, oe_ok);
      send(`SNV_OP_NOP, 4'h5, 16'h0);
      chk1(wel, 1'b1);
      send(`SNV_OP_DISABLE, 4'h0, 16'h0);
      chk1(wel, 1'b0);
      send(`SNV_OP_WRITE, 4'h5, 16'h1234);
      rdchk(4'h5, 16'h96F0);
      send(`SNV_OP_ENABLE, 4'h0, 16'h0);
      send(`SNV_OP_STORE, 4'h0, 16'h0);
      chk1(hit, 1'b1);
      chk1(wel, 1'b0);
      send(`SNV_OP_ENABLE, 4'h0, 16'h0);
      send(`SNV_OP_WRITE, 4'h5, 16'hFFFF);
      rdchk(4'h5, 16'hFFFF);
      send(`SNV_OP_RECALL, 4'h0, 16'h0);
      chk1(hit, 1'b1);
      rdchk(4'h5, 16'h96F0);
      send(`SNV_OP_DISABLE, 4'h0, 16'h0);
      send(`SNV_OP_STORE, 4'h0, 16'h0);
      chk1(hit, 1'b0);
      pins(1'b0, 1'b1);
      chk1(hit, 1'b0);
      send(`SNV_OP_ENABLE, 4'h0, 16'h0);
      send(`SNV_OP_WRITE, 4'h5, 16'h1357);
      pins(1'b0, 1'b0);
      chk1(hit, 1'b1);
      chk1(wel, 1'b0);
      send(`SNV_OP_ENABLE, 4'h0, 16'h0);
      send(`SNV_OP_WRITE, 4'h5, 16'hAAAA);
      pins(1'b1, 1'b0);
      chk1(hit, 1'b1);
      rdchk(4'h5, 16'h1357);
      send(`SNV_OP_ENABLE, 4'h0, 16'h0);
      low_sup <= 1'b1;
      repeat (8) @(posedge i_sys_clk);
      chk1(wel, 1'b0);
      send(`SNV_OP_STORE, 4'h0, 16'h0);
      chk1(hit, 1'b0);
      low_sup <= 1'b0;
      close_out();
   end
   initial
   begin
      repeat (90000) @(posedge i_sys_clk);
      err_total++;
      close_out();
   end
endmodule : serial_nvram_command_port_tb
